// File: logic/csm_params.svh
// Constants for the CPU state and memory-map block
// Overview of operation
// - Decode a flat 64KB space; every address reachable for data access.
// - Program memory runs from zero to 3FFFH, or 5FFFH on larger variants.
// - Vector area 0000H-003FH holds addresses, low byte even, high byte odd.
// - Reset 0000H, watchdog 0004H, externals 0006H/0008H, break 003EH.
// - Table call reads its entry address from 0040H through 007FH.
// - Short call reaches only 0800H to 0FFFH.
// - High-speed RAM FC00H-FEFFH, data and stack only, never executed.
// - Buffer RAM F9C0H-F9DFH holds serial data, else ordinary RAM.
// - Display RAM FA00H-FA6FH, also usable as normal data RAM.
// - Peripheral registers sit at FF00H-FFFFH; unassigned slots stay untouched.
// - Program counter advances by instruction length or loads branch targets.
// - Reset loads program counter from vector bytes 0000H and 0001H.
// - Flag byte pushed on interrupt or push, restored by returns or pop.
// - Flag byte resets to 02H.
// - Enable flag low blocks maskable requests; cleared by mask, set by unmask.
// - Zero flag set when result is zero, cleared otherwise.
// - Two bank-select flags chosen by the bank-switch instruction.
// - Half-carry set on carry out of or borrow into bit 3.
// - Low-priority requests refused while in-service flag is 0; need enable too.
// - Carry captures arithmetic overflow, rotate bit-out, and bit accumulator.
// - Stack pointer pre-decrements on write, post-increments on read.
// - General registers FEE0H-FEFFH, four banks of eight, bytes or pairs.
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH
`define CSM_ROM_END_SMALL 16'h3fff
`define CSM_ROM_END_LARGE 16'h5fff
`define CSM_VEC_END 16'h003f
`define CSM_VEC_RESET 16'h0000
`define CSM_VEC_WDT 16'h0004
`define CSM_VEC_EXT0 16'h0006
`define CSM_VEC_EXT1 16'h0008
`define CSM_VEC_BREAK 16'h003e
`define CSM_TBL_BASE 16'h0040
`define CSM_TBL_END 16'h007f
`define CSM_SCALL_BASE 16'h0800
`define CSM_SCALL_END 16'h0fff
`define CSM_HRAM_BASE 16'hfc00
`define CSM_HRAM_END 16'hfeff
`define CSM_BUF_BASE 16'hf9c0
`define CSM_BUF_END 16'hf9df
`define CSM_DISP_BASE 16'hfa00
`define CSM_DISP_END 16'hfa6f
`define CSM_PERI_BASE 16'hff00
`define CSM_GREG_BASE 16'hfee0
`define CSM_FLAG_RESET 8'h02
`define CSM_SP_RESET 16'h0000
`define CSM_F_CARRY 0
`define CSM_F_PRIO 1
`define CSM_F_BANK0 3
`define CSM_F_HALF 4
`define CSM_F_BANK1 5
`define CSM_F_Z 6
`define CSM_F_IRQEN 7
`endif

// File: logic/csm_pkg.sv
// Types shared by the CPU state and memory-map block
package csm_pkg;
    typedef enum logic [7:0] {
        CSM_R_NONE = 8'h00, CSM_R_ROM = 8'h01, CSM_R_HRAM = 8'h02, CSM_R_BUF = 8'h04,
        CSM_R_DISP = 8'h08, CSM_R_PERI = 8'h10, CSM_R_GREG = 8'h20, CSM_R_VEC = 8'h40,
        CSM_R_TBL = 8'h80
    } csm_region_t;
    typedef enum logic [3:0] {
        CSM_S_RESET0 = 4'h1, CSM_S_RESET1 = 4'h2, CSM_S_RUN = 4'h4, CSM_S_HALT = 4'h8
    } csm_state_t;
endpackage

// File: logic/csm_core_state.sv
// CPU architectural state, memory map decode and banked register file
`timescale 1ns/100ps
`default_nettype none
`include "csm_params.svh"
module csm_core_state #(
    parameter bit LARGE_ROM = 1'b1
) (
    input wire logic REF_CLK,
    input wire logic RST,
    // Memory port used by the core for the reset vector fetch
    output logic [15:0] VEC_ADDR,
    input wire logic [7:0] VEC_DATA,
    // Instruction sequencing
    input wire logic STEP,
    input wire logic [1:0] STEP_LEN,
    input wire logic BRANCH,
    input wire logic [15:0] BRANCH_TARGET,
    input wire logic TABLE_CALL,
    input wire logic [4:0] TABLE_INDEX,
    input wire logic SHORT_CALL,
    input wire logic [10:0] SHORT_OFFSET,
    input wire logic [2:0] VEC_SELECT,
    input wire logic VEC_TAKE,
    // Flag controls
    input wire logic FLAG_LOAD,
    input wire logic [7:0] FLAG_IN,
    input wire logic ALU_UPD,
    input wire logic [8:0] ALU_SUM,
    input wire logic ALU_HALF,
    input wire logic ROTATE,
    input wire logic ROT_BIT,
    input wire logic BIT_LOAD,
    input wire logic BIT_VAL,
    input wire logic MASK_ALL,
    input wire logic UNMASK_ALL,
    input wire logic BANK_SWITCH,
    input wire logic [1:0] BANK_NEW,
    // Interrupt request qualification
    input wire logic IRQ_REQ,
    input wire logic IRQ_LOW_PRIO,
    output logic IRQ_ACCEPT,
    // Stack
    input wire logic SP_LOAD,
    input wire logic [15:0] SP_IN,
    input wire logic PUSH,
    input wire logic POP,
    // Data address decode
    input wire logic [15:0] DATA_ADDR,
    input wire logic FETCH,
    output logic [7:0] REGION,
    output logic EXEC_FAULT,
    // General register file
    input wire logic GR_WE,
    input wire logic GR_PAIR,
    input wire logic [2:0] GR_IDX,
    input wire logic [15:0] GR_WDATA,
    output logic [15:0] GR_RDATA,
    // Architectural state
    output logic [15:0] PROGRAM_COUNTER,
    output logic [7:0] PROCESSOR_FLAG_BYTE,
    output logic [15:0] STACK_POINTER,
    output logic READY
);
    // Only the two program memory sizes are decoded; anything else is refused
    if (LARGE_ROM !== 1'b0 && LARGE_ROM !== 1'b1) begin : g_bad_rom
        $error("LARGE_ROM must be 0 or 1");
    end

    logic [15:0] program_counter_r, program_counter_nxt;
    logic [7:0] processor_flag_byte_r, processor_flag_byte_nxt;
    logic [15:0] stack_pointer_r, stack_pointer_nxt;
    logic [7:0] vec_low_r;
    logic [7:0] greg_r [0:31];
    csm_pkg::csm_state_t state_r;

    // ------------------------------------------------------------
    // Memory map decode
    // ------------------------------------------------------------
    wire [15:0] rom_end = LARGE_ROM ? `CSM_ROM_END_LARGE : `CSM_ROM_END_SMALL;
    wire in_rom = DATA_ADDR <= rom_end;
    wire in_vec = DATA_ADDR <= `CSM_VEC_END;
    wire in_tbl = DATA_ADDR >= `CSM_TBL_BASE && DATA_ADDR <= `CSM_TBL_END;
    wire in_hram = DATA_ADDR >= `CSM_HRAM_BASE && DATA_ADDR <= `CSM_HRAM_END;
    wire in_greg = DATA_ADDR >= `CSM_GREG_BASE && DATA_ADDR <= `CSM_HRAM_END;
    wire in_buf = DATA_ADDR >= `CSM_BUF_BASE && DATA_ADDR <= `CSM_BUF_END;
    wire in_disp = DATA_ADDR >= `CSM_DISP_BASE && DATA_ADDR <= `CSM_DISP_END;
    wire in_peri = DATA_ADDR >= `CSM_PERI_BASE;
    // Whole 16-bit space decodes; unlisted addresses report no region
    wire [7:0] region_w = in_vec ? csm_pkg::CSM_R_VEC :
        in_tbl ? csm_pkg::CSM_R_TBL :
        in_rom ? csm_pkg::CSM_R_ROM :
        in_greg ? csm_pkg::CSM_R_GREG :
        in_hram ? csm_pkg::CSM_R_HRAM :
        in_buf ? csm_pkg::CSM_R_BUF :
        in_disp ? csm_pkg::CSM_R_DISP :
        in_peri ? csm_pkg::CSM_R_PERI : csm_pkg::CSM_R_NONE;
    assign REGION = region_w;
    // Fetching from RAM areas is flagged so the core can refuse it
    assign EXEC_FAULT = FETCH && (in_hram || in_buf || in_disp || in_peri);

    // ------------------------------------------------------------
    // Interrupt qualification
    // ------------------------------------------------------------
    wire irq_en_w = processor_flag_byte_r[`CSM_F_IRQEN];
    wire in_svc_w = processor_flag_byte_r[`CSM_F_PRIO];
    assign IRQ_ACCEPT = (state_r == csm_pkg::CSM_S_RUN) && IRQ_REQ && irq_en_w
        && !(IRQ_LOW_PRIO && !in_svc_w);

    // ------------------------------------------------------------
    // Vector and target selection
    // ------------------------------------------------------------
    wire [15:0] vec_sel = (VEC_SELECT == 3'h1) ? `CSM_VEC_WDT :
        (VEC_SELECT == 3'h2) ? `CSM_VEC_EXT0 :
        (VEC_SELECT == 3'h3) ? `CSM_VEC_EXT1 :
        (VEC_SELECT == 3'h4) ? `CSM_VEC_BREAK : `CSM_VEC_RESET;
    wire [15:0] tbl_addr = `CSM_TBL_BASE | {10'h000, TABLE_INDEX, 1'b0};
    wire [15:0] scall_tgt = `CSM_SCALL_BASE | {5'h00, SHORT_OFFSET};
    wire reset_phase = state_r == csm_pkg::CSM_S_RESET0 || state_r == csm_pkg::CSM_S_RESET1;
    // During reset the vector port walks 0000H then 0001H; later it shows table or vector
    assign VEC_ADDR = (state_r == csm_pkg::CSM_S_RESET1) ? (`CSM_VEC_RESET | 16'h0001) :
        reset_phase ? `CSM_VEC_RESET : (TABLE_CALL ? tbl_addr : vec_sel);

    // ------------------------------------------------------------
    // Program counter next value
    // ------------------------------------------------------------
    always_comb begin
        program_counter_nxt = program_counter_r;
        if (state_r == csm_pkg::CSM_S_RESET1) begin
            program_counter_nxt = {VEC_DATA, vec_low_r};
        end else if (state_r == csm_pkg::CSM_S_RUN) begin
            if (SHORT_CALL) begin
                program_counter_nxt = scall_tgt;
            end else if (BRANCH || TABLE_CALL || VEC_TAKE) begin
                program_counter_nxt = BRANCH_TARGET;
            end else if (STEP) begin
                program_counter_nxt = program_counter_r + {14'h0000, STEP_LEN};
            end
        end
    end

    // ------------------------------------------------------------
    // Flag byte next value
    // ------------------------------------------------------------
    always_comb begin
        processor_flag_byte_nxt = processor_flag_byte_r;
        if (state_r == csm_pkg::CSM_S_RUN) begin
            if (FLAG_LOAD) begin
                processor_flag_byte_nxt = FLAG_IN;
            end
            if (ALU_UPD) begin
                processor_flag_byte_nxt[`CSM_F_Z] = ALU_SUM[7:0] == 8'h00;
                processor_flag_byte_nxt[`CSM_F_HALF] = ALU_HALF;
                processor_flag_byte_nxt[`CSM_F_CARRY] = ALU_SUM[8];
            end
            if (ROTATE) begin
                processor_flag_byte_nxt[`CSM_F_CARRY] = ROT_BIT;
            end
            if (BIT_LOAD) begin
                processor_flag_byte_nxt[`CSM_F_CARRY] = BIT_VAL;
            end
            if (BANK_SWITCH) begin
                processor_flag_byte_nxt[`CSM_F_BANK1] = BANK_NEW[1];
                processor_flag_byte_nxt[`CSM_F_BANK0] = BANK_NEW[0];
            end
            if (UNMASK_ALL) begin
                processor_flag_byte_nxt[`CSM_F_IRQEN] = 1'b1;
            end
            // Clearing wins over unmask so an accepted request leaves the enable flag low
            if (MASK_ALL || IRQ_ACCEPT) begin
                processor_flag_byte_nxt[`CSM_F_IRQEN] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Stack pointer next value
    // ------------------------------------------------------------
    always_comb begin
        stack_pointer_nxt = stack_pointer_r;
        if (SP_LOAD) begin
            stack_pointer_nxt = SP_IN;
        end else if (PUSH && !POP) begin
            stack_pointer_nxt = stack_pointer_r - 16'h0001;
        end else if (POP && !PUSH) begin
            stack_pointer_nxt = stack_pointer_r + 16'h0001;
        end
    end

    // Address-visible stack pointer: push slot is below, pop slot is current
    assign STACK_POINTER = stack_pointer_r;

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // Stack pointer starts at zero here though software must set it
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_r <= csm_pkg::CSM_S_RESET0;
            program_counter_r <= `CSM_VEC_RESET;
            processor_flag_byte_r <= `CSM_FLAG_RESET;
            stack_pointer_r <= `CSM_SP_RESET;
            vec_low_r <= 8'h00;
        end else begin
            case (state_r)
                csm_pkg::CSM_S_RESET0: state_r <= csm_pkg::CSM_S_RESET1;
                csm_pkg::CSM_S_RESET1: state_r <= csm_pkg::CSM_S_RUN;
                csm_pkg::CSM_S_RUN: state_r <= csm_pkg::CSM_S_RUN;
                default: state_r <= csm_pkg::CSM_S_RUN;
            endcase
            if (state_r == csm_pkg::CSM_S_RESET0) begin
                vec_low_r <= VEC_DATA;
            end
            program_counter_r <= program_counter_nxt;
            processor_flag_byte_r <= processor_flag_byte_nxt;
            stack_pointer_r <= stack_pointer_nxt;
        end
    end

    // ------------------------------------------------------------
    // Banked general registers
    // ------------------------------------------------------------
    wire [1:0] bank_w = {processor_flag_byte_r[`CSM_F_BANK1], processor_flag_byte_r[`CSM_F_BANK0]};
    wire [4:0] gr_lo = {bank_w, GR_PAIR ? {GR_IDX[1:0], 1'b0} : GR_IDX};
    wire [4:0] gr_hi = {bank_w, GR_IDX[1:0], 1'b1};
    assign GR_RDATA = GR_PAIR ? {greg_r[gr_hi], greg_r[gr_lo]} : {8'h00, greg_r[gr_lo]};

    // One write port; pairs write both bytes at once
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_greg
            always_ff @(posedge REF_CLK) begin
                if (RST) begin
                    greg_r[gi] <= 8'h00;
                end else if (GR_WE && gr_lo == 5'(gi)) begin
                    greg_r[gi] <= GR_WDATA[7:0];
                end else if (GR_WE && GR_PAIR && gr_hi == 5'(gi)) begin
                    greg_r[gi] <= GR_WDATA[15:8];
                end
            end
        end
    endgenerate

    assign PROGRAM_COUNTER = program_counter_r;
    assign PROCESSOR_FLAG_BYTE = processor_flag_byte_r;
    assign READY = state_r == csm_pkg::CSM_S_RUN;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    reset_vector_a: assert property (@(posedge REF_CLK) disable iff (RST)
        state_r == csm_pkg::CSM_S_RESET1 |=> program_counter_r == {$past(VEC_DATA), vec_low_r})
        else $error("reset vector not loaded");
    flag_reset_a: assert property (@(posedge REF_CLK) $fell(RST) |->
        processor_flag_byte_r == 8'h02) else $error("flag byte reset wrong");
    ie_clear_a: assert property (@(posedge REF_CLK) disable iff (RST)
        IRQ_ACCEPT |=> !processor_flag_byte_r[`CSM_F_IRQEN]) else $error("enable not cleared");
    low_prio_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (IRQ_LOW_PRIO && !in_svc_w) || !irq_en_w |-> !IRQ_ACCEPT) else $error("blocked irq taken");
    zero_flag_a: assert property (@(posedge REF_CLK) disable iff (RST)
        READY && ALU_UPD |=> processor_flag_byte_r[`CSM_F_Z] == ($past(ALU_SUM[7:0]) == 8'h00))
        else $error("zero flag wrong");
    sp_push_a: assert property (@(posedge REF_CLK) disable iff (RST)
        PUSH && !POP && !SP_LOAD |=> stack_pointer_r == $past(stack_pointer_r) - 16'h0001)
        else $error("stack not predecremented");
    pc_step_a: assert property (@(posedge REF_CLK) disable iff (RST)
        READY && STEP && !BRANCH && !TABLE_CALL && !VEC_TAKE && !SHORT_CALL |=>
        program_counter_r == $past(program_counter_r) + {14'h0000, $past(STEP_LEN)})
        else $error("pc step wrong");
    short_call_a: assert property (@(posedge REF_CLK) disable iff (RST)
        READY && SHORT_CALL |=> program_counter_r[15:11] == 5'h01) else $error("short call range");
    exec_ram_a: assert property (@(posedge REF_CLK) disable iff (RST)
        FETCH && REGION == csm_pkg::CSM_R_HRAM |-> EXEC_FAULT) else $error("ram fetch allowed");
    sp_pop_a: assert property (@(posedge REF_CLK) disable iff (RST)
        POP && !PUSH && !SP_LOAD |=> stack_pointer_r == $past(stack_pointer_r) + 16'h0001)
        else $error("stack not postincremented");
    sp_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
        PUSH && POP && !SP_LOAD |=> $stable(stack_pointer_r)) else $error("stack moved");
    half_carry_a: assert property (@(posedge REF_CLK) disable iff (RST)
        READY && ALU_UPD |=> processor_flag_byte_r[`CSM_F_HALF] == $past(ALU_HALF))
        else $error("half carry wrong");
    carry_sum_a: assert property (@(posedge REF_CLK) disable iff (RST)
        READY && ALU_UPD && !ROTATE && !BIT_LOAD |=>
        processor_flag_byte_r[`CSM_F_CARRY] == $past(ALU_SUM[8])) else $error("carry wrong");
    bank_switch_a: assert property (@(posedge REF_CLK) disable iff (RST)
        READY && BANK_SWITCH |=> bank_w == $past(BANK_NEW)) else $error("bank not switched");
    unmask_a: assert property (@(posedge REF_CLK) disable iff (RST)
        READY && UNMASK_ALL && !MASK_ALL && !IRQ_ACCEPT |=> processor_flag_byte_r[`CSM_F_IRQEN])
        else $error("unmask ignored");
    table_addr_a: assert property (@(posedge REF_CLK) disable iff (RST)
        READY && TABLE_CALL |-> VEC_ADDR[15:6] == 10'h001 && !VEC_ADDR[0])
        else $error("table entry outside table");
    break_vector_a: assert property (@(posedge REF_CLK) disable iff (RST)
        READY && !TABLE_CALL && VEC_SELECT == 3'h4 |-> VEC_ADDR == 16'h003e)
        else $error("break vector wrong");
    peri_region_a: assert property (@(posedge REF_CLK) disable iff (RST)
        DATA_ADDR[15:8] == 8'hff |-> REGION == csm_pkg::CSM_R_PERI) else $error("peripheral decode");
    not_ready_a: assert property (@(posedge REF_CLK)
        RST |=> !READY) else $error("ready during reset");
    flag_load_a: assert property (@(posedge REF_CLK) disable iff (RST)
        READY && FLAG_LOAD && !ALU_UPD && !ROTATE && !BIT_LOAD && !BANK_SWITCH && !UNMASK_ALL
        && !MASK_ALL && !IRQ_ACCEPT |=> processor_flag_byte_r == $past(FLAG_IN))
        else $error("flag load lost");
endmodule
`default_nettype wire

// File: tb/cpu_state_and_memory_map_tb_top.sv
// Self-checking testbench for the CPU state and memory-map block
`timescale 1ns/100ps
`default_nettype none
module cpu_state_and_memory_map_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic step = 0, branch = 0, tcall = 0, scall = 0, vtake = 0, fload = 0, alu = 0, ahalf = 0;
    logic rot = 0, rbit = 0, bload = 0, bval = 0, mask = 0, unmask = 0, bsw = 0, ireq = 0;
    logic ilow = 0, spload = 0, push = 0, pop = 0, fetch = 0, grwe = 0, grpair = 0;
    logic [1:0] slen = 0, bnew = 0;
    logic [2:0] vsel = 0, gidx = 0;
    logic [4:0] tidx = 0;
    logic [10:0] soff = 0;
    logic [8:0] asum = 0;
    logic [7:0] fin = 0, vdata, region, flags;
    logic [15:0] btgt = 0, spin = 0, daddr = 0, gwd = 0, vaddr, grd, pc, sp, v;
    logic iacc, efault, ready;
    logic [7:0] region_s;
    logic [31:0] seed = 32'he6a3ef5a;
    int fails = 0;
    int n_checks = 0;
    logic [15:0] vexp [5] = '{16'h0000, 16'h0004, 16'h0006, 16'h0008, 16'h003e};
    logic [15:0] corner [23] = '{16'h0000, 16'h003f, 16'h0040, 16'h007f, 16'h0080, 16'h5fff,
        16'h3fff, 16'h4000,
        16'h6000, 16'hf9bf, 16'hf9c0, 16'hf9df, 16'hf9e0, 16'hfa00, 16'hfa6f, 16'hfa70,
        16'hfbff, 16'hfc00, 16'hfedf, 16'hfee0, 16'hfeff, 16'hff00, 16'hffff};

    // Vector memory answers in the same cycle; a fixed pattern keeps the expected target known
    assign vdata = vaddr[7:0] ^ 8'ha5;

    always #2.5 ref_clk = ~ref_clk;

    csm_core_state #(.LARGE_ROM(1'b1)) u_dut (.REF_CLK(ref_clk), .RST(rst), .VEC_ADDR(vaddr),
        .VEC_DATA(vdata), .STEP(step), .STEP_LEN(slen), .BRANCH(branch), .BRANCH_TARGET(btgt),
        .TABLE_CALL(tcall), .TABLE_INDEX(tidx), .SHORT_CALL(scall), .SHORT_OFFSET(soff),
        .VEC_SELECT(vsel), .VEC_TAKE(vtake), .FLAG_LOAD(fload), .FLAG_IN(fin), .ALU_UPD(alu),
        .ALU_SUM(asum), .ALU_HALF(ahalf), .ROTATE(rot), .ROT_BIT(rbit), .BIT_LOAD(bload),
        .BIT_VAL(bval), .MASK_ALL(mask), .UNMASK_ALL(unmask), .BANK_SWITCH(bsw),
        .BANK_NEW(bnew), .IRQ_REQ(ireq), .IRQ_LOW_PRIO(ilow), .IRQ_ACCEPT(iacc),
        .SP_LOAD(spload), .SP_IN(spin), .PUSH(push), .POP(pop), .DATA_ADDR(daddr),
        .FETCH(fetch), .REGION(region), .EXEC_FAULT(efault), .GR_WE(grwe), .GR_PAIR(grpair),
        .GR_IDX(gidx), .GR_WDATA(gwd), .GR_RDATA(grd), .PROGRAM_COUNTER(pc),
        .PROCESSOR_FLAG_BYTE(flags), .STACK_POINTER(sp), .READY(ready));

    // Small program memory variant sees the same inputs; only its decode is compared
    csm_core_state #(.LARGE_ROM(1'b0)) u_small (.REF_CLK(ref_clk), .RST(rst), .VEC_ADDR(),
        .VEC_DATA(vdata), .STEP(step), .STEP_LEN(slen), .BRANCH(branch), .BRANCH_TARGET(btgt),
        .TABLE_CALL(tcall), .TABLE_INDEX(tidx), .SHORT_CALL(scall), .SHORT_OFFSET(soff),
        .VEC_SELECT(vsel), .VEC_TAKE(vtake), .FLAG_LOAD(fload), .FLAG_IN(fin), .ALU_UPD(alu),
        .ALU_SUM(asum), .ALU_HALF(ahalf), .ROTATE(rot), .ROT_BIT(rbit), .BIT_LOAD(bload),
        .BIT_VAL(bval), .MASK_ALL(mask), .UNMASK_ALL(unmask), .BANK_SWITCH(bsw),
        .BANK_NEW(bnew), .IRQ_REQ(ireq), .IRQ_LOW_PRIO(ilow), .IRQ_ACCEPT(),
        .SP_LOAD(spload), .SP_IN(spin), .PUSH(push), .POP(pop), .DATA_ADDR(daddr),
        .FETCH(fetch), .REGION(region_s), .EXEC_FAULT(), .GR_WE(grwe), .GR_PAIR(grpair),
        .GR_IDX(gidx), .GR_WDATA(gwd), .GR_RDATA(), .PROGRAM_COUNTER(),
        .PROCESSOR_FLAG_BYTE(), .STACK_POINTER(), .READY());

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Galois shift register; fixed seed keeps every run the same
    function automatic void rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    // One edge takes the request, then every strobe drops so nothing repeats
    task automatic go();
        @(posedge ref_clk);
        {step, branch, tcall, scall, vtake, fload, alu, rot, bload} <= '0;
        {mask, unmask, bsw, ireq, spload, push, pop, grwe} <= '0;
        #1;
    endtask

    // Priority mirrors the decode order: vectors, table, program, registers, RAMs, peripherals
    function automatic logic [7:0] exp_region(input logic [15:0] a);
        if (a <= 16'h003f) return csm_pkg::CSM_R_VEC;
        if (a <= 16'h007f) return csm_pkg::CSM_R_TBL;
        if (a <= 16'h5fff) return csm_pkg::CSM_R_ROM;
        if (a >= 16'hfee0 && a <= 16'hfeff) return csm_pkg::CSM_R_GREG;
        if (a >= 16'hfc00 && a <= 16'hfeff) return csm_pkg::CSM_R_HRAM;
        if (a >= 16'hf9c0 && a <= 16'hf9df) return csm_pkg::CSM_R_BUF;
        if (a >= 16'hfa00 && a <= 16'hfa6f) return csm_pkg::CSM_R_DISP;
        if (a >= 16'hff00) return csm_pkg::CSM_R_PERI;
        return csm_pkg::CSM_R_NONE;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog sized well above the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        #1 chk(flags, 16'h02, "flag reset");
        chk({15'h0, ready}, 16'h0000, "ready in reset");
        @(posedge ref_clk);
        rst <= 1'b0;
        #1 chk(vaddr, 16'h0000, "reset low byte");
        @(posedge ref_clk);
        #1 chk(vaddr, 16'h0001, "reset high byte");
        chk({15'h0, ready}, 16'h0000, "ready before vector");
        for (int i = 0; i < 6 && ready !== 1'b1; i++) @(posedge ref_clk);
        #1 chk(pc, 16'ha4a5, "reset target");
        chk({15'h0, ready}, 16'h0001, "ready after vector");
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            vsel <= i[2:0];
            #1 chk(vaddr, vexp[i], "vector address");
        end
        for (int i = 0; i < 24; i++) begin
            rnd();
            @(posedge ref_clk);
            btgt <= seed[31:16];
            slen <= seed[1:0];
            soff <= seed[12:2];
            tidx <= (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : seed[20:16];
            case (i < 2 ? 2'd1 : seed[14:13])
                2'd0: step <= 1'b1;
                2'd1: tcall <= 1'b1;
                2'd2: scall <= 1'b1;
                default: vtake <= 1'b1;
            endcase
            v = pc + {14'h0, seed[1:0]};
            if (i < 2 || seed[14:13] == 2'd1) begin
                #1 chk(vaddr, 16'h0040 | {10'h0, tidx, 1'b0}, "table entry");
            end
            if (i < 2 || seed[14:13] != 2'd0) v = seed[31:16];
            if (i >= 2 && seed[14:13] == 2'd2) v = 16'h0800 | {5'h0, seed[12:2]};
            go();
            chk(pc, v, "program counter");
        end
        $display("test sequencing done");
        for (int i = 0; i < 63; i++) begin
            rnd();
            @(posedge ref_clk);
            daddr <= (i < 23) ? corner[i] : seed[15:0];
            fetch <= seed[16];
            #1 chk({8'h0, region}, {8'h0, exp_region(daddr)},
                "region");
            chk({8'h0, region_s}, {8'h0, (daddr >= 16'h4000 && daddr <= 16'h5fff) ? 8'h00 :
                exp_region(daddr)}, "small rom end");
            chk(efault, fetch & (daddr >= 16'hfc00 || exp_region(daddr) == csm_pkg::CSM_R_BUF
                || exp_region(daddr) == csm_pkg::CSM_R_DISP), "execute fault");
        end
        $display("test decode done");
        for (int i = 0; i < 20; i++) begin
            rnd();
            @(posedge ref_clk);
            asum <= (i == 0) ? 9'h100 : seed[8:0];
            ahalf <= seed[9];
            rbit <= seed[10];
            bval <= seed[11];
            alu <= 1'b1;
            go();
            chk(flags[6], asum[7:0] == 8'h00, "zero flag");
            chk({flags[4], flags[0]}, {ahalf, asum[8]}, "carry flags");
            @(posedge ref_clk);
            rot <= seed[12];
            bload <= ~seed[12];
            go();
            chk(flags[0], seed[12] ? rbit : bval, "carry shift or bit");
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            fload <= 1'b1;
            fin <= {i[0], 5'h00, i[1], 1'b0};
            go();
            chk(flags, fin, "flag load");
            @(posedge ref_clk);
            ireq <= 1'b1;
            ilow <= i[2];
            #1 chk(iacc, i[0] & ~(i[2] & ~i[1]), "irq accept");
            go();
        end
        @(posedge ref_clk);
        unmask <= 1'b1;
        go();
        chk(flags[7], 1'b1, "unmask");
        @(posedge ref_clk);
        {mask, unmask} <= 2'b11;
        go();
        chk(flags[7], 1'b0, "mask wins");
        $display("test flags done");
        // Each bank gets its own pattern so a bank that ignores the select reads back wrong
        for (int p = 0; p < 2; p++) begin
            for (int b = 0; b < 4; b++) begin
                v = {6'h0, b[1:0], 6'h0, b[1:0]} ^ 16'h5a3c;
                @(posedge ref_clk);
                bsw <= 1'b1;
                bnew <= b[1:0];
                go();
                chk({flags[5], flags[3]}, b[1:0], "bank select");
                @(posedge ref_clk);
                {grwe, grpair, gidx, gwd} <= {p == 0, 1'b1, 3'h1, v};
                #1 chk(grd, (p == 0) ? 16'h0000 : v, "pair read");
                go();
                {grpair, gidx} <= 4'h2;
                #1 chk(grd, {8'h00, v[7:0]}, "low byte");
            end
        end
        $display("test banks done");
        @(posedge ref_clk);
        {spload, spin} <= {1'b1, 16'hfe20};
        go();
        chk(sp, 16'hfe20, "stack load");
        @(posedge ref_clk);
        push <= 1'b1;
        go();
        chk(sp, 16'hfe1f, "stack push");
        @(posedge ref_clk);
        {push, pop} <= 2'b11;
        go();
        chk(sp, 16'hfe1f, "push and pop");
        @(posedge ref_clk);
        pop <= 1'b1;
        go();
        chk(sp, 16'hfe20, "stack pop");
        $display("test stack done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
